// ### rtl/ptt_pkg.sv
// Shared constants and types of the power transfer termination block
package ptt_pkg;
    // APB register byte offsets
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_COUNT  = 8'h08;
    // Control register fields and reset value
    localparam int CTRL_EN_BIT  = 0;
    localparam int CTRL_CLR_BIT = 1;
    localparam logic CTRL_EN_RST = 1'b1;
    // Status register field positions
    localparam int ST_DONE_BIT  = 0;
    localparam int ST_PEND_BIT  = 1;
    localparam int ST_PMA_BIT   = 2;
    localparam int ST_NCONV_BIT = 3;
    localparam int ST_OVP_BIT   = 4;
    localparam int ST_SURGE_BIT = 5;
    localparam int ST_CODE_LSB  = 8;
    // Index of each synchronised comparator input
    localparam int SYNC_W    = 13;
    localparam int I_AD      = 0;
    localparam int I_CTRLH   = 1;
    localparam int I_CTRLL   = 2;
    localparam int I_HOT     = 3;
    localparam int I_TJ      = 4;
    localparam int I_RLIM    = 5;
    localparam int I_TERM    = 6;
    localparam int I_LIMDIS  = 7;
    localparam int I_PING    = 8;
    localparam int I_CONV    = 9;
    localparam int I_OVP     = 10;
    localparam int I_SURGE   = 11;
    localparam int I_PMA     = 12;
    // Termination reason codes actually sent
    localparam logic [2:0] RSN_UNKNOWN  = 3'h0;
    localparam logic [2:0] RSN_CHARGED  = 3'h1;
    localparam logic [2:0] RSN_FAULT    = 3'h2;
    localparam logic [2:0] RSN_OVERTEMP = 3'h3;
    localparam logic [2:0] RSN_OVERVOLT = 3'h4;
    localparam logic [2:0] RSN_MAX_SENT = 3'h4;
    // Startup non-convergence packet budget
    localparam logic [6:0] STARTUP_PKTS = 7'h40;
    // Communication current limit bands, in mA
    localparam logic [11:0] LIM_LO_MA  = 12'h064;
    localparam logic [11:0] LIM_HI_MA  = 12'h190;
    localparam logic [11:0] LIM_OFS_MA = 12'h032;
    // Error packet pacing
    localparam int unsigned CLK_KHZ  = 250000;
    localparam int unsigned FAST_MS  = 30;
    localparam int unsigned SLOW_MS  = 250;
    localparam int unsigned FAST_CYC = FAST_MS * CLK_KHZ;
    localparam int unsigned SLOW_CYC = SLOW_MS * CLK_KHZ;
    localparam int TMR_W = 26;
    typedef enum logic [2:0] {
        S_RUN  = 3'b001,
        S_PEND = 3'b010,
        S_DONE = 3'b100
    } ptt_state_t;
endpackage

// ### rtl/ptt_sync.sv
// Two-stage synchroniser for asynchronous comparator levels
`timescale 1ns/100ps
`default_nettype none
module ptt_sync #(
    parameter int W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         ce,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } ptt_sync_t;
    ptt_sync_t s;
    ptt_sync_t next_s;

    always_comb
    begin
        next_s    = s;
        next_s.s1 = d;
        next_s.s2 = s.s1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            s <= '0;
        else if (ce)
            s <= next_s;
    end

    assign q = s.s2;
endmodule
`default_nettype wire

// ### rtl/ptt_pacer.sv
// Error packet pacing timer with fast and slow periods
`timescale 1ns/100ps
`default_nettype none
module ptt_pacer #(
    parameter int unsigned FAST = ptt_pkg::FAST_CYC,
    parameter int unsigned SLOW = ptt_pkg::SLOW_CYC
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic ce,
    input  wire logic run,
    input  wire logic fast,
    output logic      tick
);
    localparam logic [ptt_pkg::TMR_W-1:0] FAST_END = ptt_pkg::TMR_W'(FAST - 1);
    localparam logic [ptt_pkg::TMR_W-1:0] SLOW_END = ptt_pkg::TMR_W'(SLOW - 1);
    typedef struct packed {
        logic [ptt_pkg::TMR_W-1:0] cnt;
        logic                      fast_q;
        logic                      tick;
    } ptt_pacer_t;
    ptt_pacer_t s;
    ptt_pacer_t next_s;

    always_comb
    begin
        next_s        = s;
        next_s.tick   = 1'b0;
        next_s.fast_q = fast;
        // A period change restarts the count so a surge answers promptly
        if (!run || fast != s.fast_q)
            next_s.cnt = '0;
        else if (s.cnt == (s.fast_q ? FAST_END : SLOW_END))
        begin
            next_s.cnt  = '0;
            next_s.tick = 1'b1;
        end
        else
            next_s.cnt = s.cnt + 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            s <= '0;
        else if (ce)
            s <= next_s;
    end

    assign tick = s.tick;
endmodule
`default_nettype wire

// ### rtl/ptt_core.sv
// Power transfer termination control with APB status and control registers
//
// Summary of operation
// R01 - Control pin above 1.4 V sends charge-complete (WPC) or end-of-charge (PMA).
// R02 - Reason is a byte 0x00..0x08; codes 0x05..0x08 are never sent.
// R03 - Adapter high gives 0x00, control high 0x01, die hot or resistor low 0x02.
// R04 - Sense below hot level or control pin below 100 mV gives 0x03.
// R05 - No rectifier convergence after 64 startup error packets gives 0x04.
// R06 - Transmitter shuts power off after a non-convergence termination.
// R07 - PMA only: termination pin above limit pin disables output, sends end-of-charge.
// R08 - WPC only: communication current limit unless enable pin is high.
// R09 - Limit none below 100 mA, load+50 to 400 mA, load-50 above.
// R10 - WPC only: pad-detect pulled low while ping memory exceeds 1.6 V.
// R11 - Transmitter idles in low power after charge complete, still pinging.
// R12 - Hot threshold sends over-temperature (WPC) or end-of-charge (PMA) per mode.
// R13 - Input surge paces error packets every 30 ms, afterwards every 250 ms.
// R14 - Rectifier overvoltage turns regulator off and asks transmitter to lower it.
// R15 - Simultaneous causes give one packet with the lowest reason code.
// R16 - Causes watched continuously; termination goes out at the next packet slot.
`timescale 1ns/100ps
`default_nettype none
module ptt_core #(
    parameter int unsigned FAST_CYC = ptt_pkg::FAST_CYC,
    parameter int unsigned SLOW_CYC = ptt_pkg::SLOW_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        adapter_over,
    input  wire logic        temp_sense_control_high,
    input  wire logic        temp_sense_control_low,
    input  wire logic        temp_sense_hot,
    input  wire logic        junction_over,
    input  wire logic        limit_resistor_low,
    input  wire logic        term_over_current_limit,
    input  wire logic        comm_limit_enable_pin,
    input  wire logic        ping_memory_high,
    input  wire logic        rectifier_converged,
    input  wire logic        rectifier_overvoltage,
    input  wire logic        input_surge,
    input  wire logic        pma_mode,
    input  wire logic        packet_slot,
    input  wire logic        startup,
    input  wire logic        comm_active,
    input  wire logic [11:0] load_ma,
    output logic             ept_send,
    output logic      [7:0]  ept_code,
    output logic             eoc_send,
    output logic             output_disable,
    output logic             regulator_off,
    output logic             error_packet_req,
    output logic             pad_detect_out_o,
    output logic             pad_detect_out_oe,
    output logic             comm_limit_on,
    output logic      [11:0] comm_limit_ma
);
    typedef struct packed {
        ptt_pkg::ptt_state_t st;
        logic [2:0]          code;
        logic                nonconv;
        logic [6:0]          cnt;
        logic                en;
        logic                ovp_q;
        logic                ept_send;
        logic [7:0]          ept_code;
        logic                eoc_send;
        logic                out_dis;
        logic                reg_off;
        logic                err_req;
        logic                pad_o;
        logic                pad_oe;
        logic                lim_on;
        logic [11:0]         lim_ma;
        logic [31:0]         prdata;
        logic                pready;
        logic                pslverr;
    } ptt_core_t;

    ptt_core_t s;
    ptt_core_t next_s;
    logic [ptt_pkg::SYNC_W-1:0] x;
    logic                       tick;
    logic                       pace_run;
    logic                       c_ad;
    logic                       c_chg;
    logic                       c_flt;
    logic                       c_hot;
    logic                       cand_any;
    logic [2:0]                 cand_code;
    logic                       acc;

    // Every comparator level comes from the analog domain
    ptt_sync #(
        .W (ptt_pkg::SYNC_W)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .d       ({pma_mode, input_surge, rectifier_overvoltage, rectifier_converged,
                   ping_memory_high, comm_limit_enable_pin, term_over_current_limit,
                   limit_resistor_low, junction_over, temp_sense_hot,
                   temp_sense_control_low, temp_sense_control_high, adapter_over}),
        .q       (x)
    );

    assign pace_run = s.en && !startup && s.st == ptt_pkg::S_RUN;

    ptt_pacer #(
        .FAST (FAST_CYC),
        .SLOW (SLOW_CYC)
    ) u_pacer (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .run     (pace_run),
        .fast    (x[ptt_pkg::I_SURGE]),
        .tick    (tick)
    );

    assign c_ad  = x[ptt_pkg::I_AD];                                     // see R03
    assign c_chg = x[ptt_pkg::I_CTRLH];                                  // see R01
    assign c_flt = x[ptt_pkg::I_TJ] | x[ptt_pkg::I_RLIM];                // see R03
    assign c_hot = x[ptt_pkg::I_HOT] | x[ptt_pkg::I_CTRLL];              // see R04
    // Termination pin cause is ignored outside PMA
    assign cand_any = c_ad | c_chg | c_flt | c_hot | s.nonconv
                    | (x[ptt_pkg::I_PMA] & x[ptt_pkg::I_TERM]);          // see R07

    // Lowest code wins when causes overlap
    always_comb
    begin
        if (c_ad)
            cand_code = ptt_pkg::RSN_UNKNOWN;                            // see R15
        else if (c_chg)
            cand_code = ptt_pkg::RSN_CHARGED;
        else if (c_flt)
            cand_code = ptt_pkg::RSN_FAULT;
        else if (c_hot)
            cand_code = ptt_pkg::RSN_OVERTEMP;                           // see R12
        else if (s.nonconv)
            cand_code = ptt_pkg::RSN_OVERVOLT;
        else
            cand_code = ptt_pkg::RSN_CHARGED;
    end

    assign acc = psel && penable;

    always_comb
    begin
        next_s          = s;
        next_s.ept_send = 1'b0;
        next_s.eoc_send = 1'b0;
        next_s.err_req  = 1'b0;
        next_s.pad_o    = 1'b0;
        next_s.ovp_q    = x[ptt_pkg::I_OVP];

        case (s.st)
            ptt_pkg::S_RUN:
            begin
                if (s.en && cand_any)
                begin
                    next_s.st   = ptt_pkg::S_PEND;                       // see R16
                    next_s.code = cand_code;
                end
            end
            ptt_pkg::S_PEND:
            begin
                if (cand_any)
                    next_s.code = cand_code;                             // see R15
                if (!s.en)
                    next_s.st = ptt_pkg::S_RUN;
                else if (packet_slot)
                begin
                    next_s.st = ptt_pkg::S_DONE;                         // see R16
                    if (x[ptt_pkg::I_PMA])
                        next_s.eoc_send = 1'b1;                          // see R01
                    else
                    begin
                        next_s.ept_send = 1'b1;                          // see R12
                        next_s.ept_code = {5'h00, cand_any ? cand_code : s.code}; // see R02
                    end
                end
            end
            ptt_pkg::S_DONE:
            begin
                // Software restart; a send in the same cycle still completes first
                if (acc && s.pready && pwrite && paddr == ptt_pkg::ADDR_CTRL
                    && pwdata[ptt_pkg::CTRL_CLR_BIT])
                begin
                    next_s.st      = ptt_pkg::S_RUN;
                    next_s.nonconv = 1'b0;
                    next_s.cnt     = '0;
                end
            end
            default:
                next_s.st = ptt_pkg::S_RUN;
        endcase

        // Startup budget of error packets before giving up on convergence
        if (startup && s.en && s.st == ptt_pkg::S_RUN && packet_slot
            && !x[ptt_pkg::I_CONV] && !s.nonconv)
        begin
            next_s.cnt = s.cnt + 1'b1;
            if (s.cnt == ptt_pkg::STARTUP_PKTS - 7'h01)
                next_s.nonconv = 1'b1;                                   // see R05
        end

        next_s.out_dis = next_s.st != ptt_pkg::S_RUN;                    // see R07
        next_s.reg_off = x[ptt_pkg::I_OVP];                              // see R14
        // Overvoltage onset asks for a correction at once, not at the next tick
        next_s.err_req = tick | (x[ptt_pkg::I_OVP] & ~s.ovp_q);          // see R13
        next_s.pad_oe  = x[ptt_pkg::I_PING] & ~x[ptt_pkg::I_PMA];        // see R10

        // Limit follows the load; it is only a target for the analog loop
        next_s.lim_on = !x[ptt_pkg::I_PMA] && !x[ptt_pkg::I_LIMDIS]
                      && comm_active && load_ma >= ptt_pkg::LIM_LO_MA;   // see R08
        if (load_ma > ptt_pkg::LIM_HI_MA)
            next_s.lim_ma = load_ma - ptt_pkg::LIM_OFS_MA;               // see R09
        else
            next_s.lim_ma = load_ma + ptt_pkg::LIM_OFS_MA;

        // One wait state: data are prepared on the first access cycle
        next_s.pready  = acc && !s.pready;
        next_s.pslverr = 1'b0;
        next_s.prdata  = '0;
        if (acc && !s.pready)
        begin
            case (paddr)
                ptt_pkg::ADDR_CTRL:
                    next_s.prdata[ptt_pkg::CTRL_EN_BIT] = s.en;
                ptt_pkg::ADDR_STATUS:
                begin
                    next_s.prdata[ptt_pkg::ST_DONE_BIT]  = s.st == ptt_pkg::S_DONE;
                    next_s.prdata[ptt_pkg::ST_PEND_BIT]  = s.st == ptt_pkg::S_PEND;
                    next_s.prdata[ptt_pkg::ST_PMA_BIT]   = x[ptt_pkg::I_PMA];
                    next_s.prdata[ptt_pkg::ST_NCONV_BIT] = s.nonconv;
                    next_s.prdata[ptt_pkg::ST_OVP_BIT]   = x[ptt_pkg::I_OVP];
                    next_s.prdata[ptt_pkg::ST_SURGE_BIT] = x[ptt_pkg::I_SURGE];
                    next_s.prdata[ptt_pkg::ST_CODE_LSB +: 3] = s.code;
                end
                ptt_pkg::ADDR_COUNT:
                    next_s.prdata[6:0] = s.cnt;
                default:
                    next_s.pslverr = 1'b1;
            endcase
        end
        if (acc && s.pready && pwrite && paddr == ptt_pkg::ADDR_CTRL)
            next_s.en = pwdata[ptt_pkg::CTRL_EN_BIT];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s    <= '0;
            s.st <= ptt_pkg::S_RUN;
            s.en <= ptt_pkg::CTRL_EN_RST;
        end
        else if (ce)
            s <= next_s;
    end

    assign prdata            = s.prdata;
    assign pready            = s.pready;
    assign pslverr           = s.pslverr;
    assign ept_send          = s.ept_send;
    assign ept_code          = s.ept_code;
    assign eoc_send          = s.eoc_send;
    assign output_disable    = s.out_dis;
    assign regulator_off     = s.reg_off;
    assign error_packet_req  = s.err_req;
    assign pad_detect_out_o  = s.pad_o;
    assign pad_detect_out_oe = s.pad_oe;
    assign comm_limit_on     = s.lim_on;
    assign comm_limit_ma     = s.lim_ma;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn || !ce);

    sequence seq_pend_slot;
        s.st == ptt_pkg::S_PEND && s.en && packet_slot;
    endsequence

    AST_CODE_RANGE: assert property (ept_send |-> ept_code <= {5'h00, ptt_pkg::RSN_MAX_SENT}) // see R02
        else $error("reserved termination code sent");

    AST_SLOT_SEND: assert property (seq_pend_slot |=> (ept_send ^ eoc_send) ##1 !ept_send && !eoc_send) // see R16
        else $error("pending termination not sent at slot");

    AST_NO_STRAY_SEND: assert property (s.st != ptt_pkg::S_PEND |=> !ept_send && !eoc_send) // see R16
        else $error("send without pending cause");

    AST_LOWEST: assert property (seq_pend_slot ##0 !x[ptt_pkg::I_PMA] && c_ad |=> ept_code == 8'h00) // see R15
        else $error("adapter cause did not win");

    AST_CHARGED: assert property (seq_pend_slot ##0 !x[ptt_pkg::I_PMA] && !c_ad && c_chg
                                  |=> ept_code == 8'h01) // see R01
        else $error("charge complete code wrong");

    AST_HOT_PMA: assert property (seq_pend_slot ##0 x[ptt_pkg::I_PMA] |=> eoc_send && !ept_send) // see R12
        else $error("PMA termination not end-of-charge");

    AST_FAULT_PEND: assert property (s.st == ptt_pkg::S_RUN && s.en && c_flt |=> s.st == ptt_pkg::S_PEND) // see R03
        else $error("fault did not arm termination");

    AST_NONCONV: assert property (startup && s.en && s.st == ptt_pkg::S_RUN && packet_slot
                                  && !x[ptt_pkg::I_CONV] && !s.nonconv && s.cnt == ptt_pkg::STARTUP_PKTS - 7'h01
                                  |=> s.nonconv ##1 s.st == ptt_pkg::S_PEND) // see R05
        else $error("non-convergence not flagged after budget");

    AST_TERM_DIS: assert property (s.st == ptt_pkg::S_RUN && s.en && x[ptt_pkg::I_PMA]
                                   && x[ptt_pkg::I_TERM] |=> output_disable) // see R07
        else $error("output not disabled on termination pin");

    AST_LIMIT_BAND: assert property (comm_limit_on && $past(load_ma) <= ptt_pkg::LIM_HI_MA
                                     |-> comm_limit_ma == $past(load_ma) + ptt_pkg::LIM_OFS_MA) // see R09
        else $error("mid band limit wrong");

    AST_LIMIT_HIGH: assert property (comm_limit_on && $past(load_ma) > ptt_pkg::LIM_HI_MA
                                     |-> comm_limit_ma == $past(load_ma) - ptt_pkg::LIM_OFS_MA) // see R09
        else $error("high band limit wrong");

    AST_LIMIT_LOW: assert property (comm_limit_on |-> $past(load_ma) >= ptt_pkg::LIM_LO_MA) // see R09
        else $error("comm limit at light load");

    AST_LIMIT_PMA: assert property (comm_limit_on |-> !$past(x[ptt_pkg::I_PMA])) // see R08
        else $error("comm limit active in PMA");

    AST_LIMIT_DIS: assert property (comm_limit_on |-> !$past(x[ptt_pkg::I_LIMDIS])) // see R08
        else $error("comm limit while disabled");

    AST_PAD: assert property (pad_detect_out_oe |-> !pad_detect_out_o && $past(x[ptt_pkg::I_PING])) // see R10
        else $error("pad detect driven without ping memory");

    AST_PAD_WPC: assert property (pad_detect_out_oe |-> !$past(x[ptt_pkg::I_PMA])) // see R10
        else $error("pad detect driven in PMA");

    AST_OVP: assert property ($rose(x[ptt_pkg::I_OVP]) |=> regulator_off && error_packet_req) // see R14
        else $error("overvoltage not handled");
endmodule
`default_nettype wire

// ### dv/ptt_tx_model.sv
// Transmitter model: packet slots and reaction to terminations
`timescale 1ns/100ps
`default_nettype none
module ptt_tx_model #(
    parameter int SLOT = 8
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       ept_send,
    input  wire logic [7:0] ept_code,
    input  wire logic       eoc_send,
    output logic            packet_slot,
    output logic            power_off,
    output logic            low_power
);
    int cnt;
    // Slots keep coming in low power, so renegotiation stays possible
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt         <= 0;
            packet_slot <= 1'b0;
            power_off   <= 1'b0;
            low_power   <= 1'b0;
        end
        else
        begin
            cnt         <= (cnt == SLOT - 1) ? 0 : cnt + 1;
            packet_slot <= (cnt == SLOT - 1);
            if (ept_send && ept_code == 8'h04)
                power_off <= 1'b1;
            if (eoc_send || (ept_send && ept_code == 8'h01))
                low_power <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ### dv/test_power_transfer_termination.sv
// Self-checking bench of the termination block
`timescale 1ns/100ps
`default_nettype none
module test_power_transfer_termination;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, er, packet_slot, power_off, low_power;
    logic [5:0]  cz = 6'h00;
    logic        term_pin = 1'b0, lim_dis = 1'b0, ping_hi = 1'b0, conv = 1'b1;
    logic        ovp = 1'b0, surge = 1'b0, pma = 1'b0, startup = 1'b0, comm = 1'b0, ce = 1'b1;
    logic [11:0] load = 12'h000;
    logic        ept_send, eoc_send, out_dis, reg_off, err_req, pd_o, pd_oe, lim_on;
    logic [7:0]  ept_code;
    logic [11:0] lim_ma;
    int          err_total = 0, n_compared = 0;
    logic [5:0]  cz_t [8] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h14, 6'h3F};
    logic [7:0]  cd_t [8] = '{8'h00, 8'h01, 8'h02, 8'h02, 8'h03, 8'h03, 8'h02, 8'h00};
    logic [11:0] ld_t [4] = '{12'h063, 12'h064, 12'h190, 12'h191};
    logic [12:0] lm_t [4] = '{13'h0000, 13'h1096, 13'h11C2, 13'h115F};

    ptt_core #(.FAST_CYC(20), .SLOW_CYC(50)) u_ptt_core (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .adapter_over(cz[0]), .temp_sense_control_high(cz[1]),
        .junction_over(cz[2]), .limit_resistor_low(cz[3]), .temp_sense_hot(cz[4]),
        .temp_sense_control_low(cz[5]), .term_over_current_limit(term_pin),
        .comm_limit_enable_pin(lim_dis), .ping_memory_high(ping_hi), .rectifier_converged(conv),
        .rectifier_overvoltage(ovp), .input_surge(surge), .pma_mode(pma),
        .packet_slot(packet_slot), .startup(startup), .comm_active(comm), .load_ma(load),
        .ept_send(ept_send), .ept_code(ept_code), .eoc_send(eoc_send), .output_disable(out_dis),
        .regulator_off(reg_off), .error_packet_req(err_req), .pad_detect_out_o(pd_o),
        .pad_detect_out_oe(pd_oe), .comm_limit_on(lim_on), .comm_limit_ma(lim_ma));

    ptt_tx_model #(.SLOT(8)) u_ptt_tx_model (
        .pclk(pclk), .presetn(presetn), .ept_send(ept_send), .ept_code(ept_code),
        .eoc_send(eoc_send), .packet_slot(packet_slot), .power_off(power_off),
        .low_power(low_power));

    always #2 pclk = ~pclk;

    task automatic close_out();
        $display("Compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
            err_total++;
        end
    endtask

    task automatic tmo(input int i, input int lim);
        if (i >= lim)
        begin
            $display("MISMATCH t=%0t wait timed out", $time);
            err_total++;
            close_out();
        end
    endtask

    // Request held until the edge that samples pready high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 50; i++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        tmo(i, 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic w4();
        repeat (4) @(posedge pclk);
        #1;
    endtask

    task automatic term(input logic [7:0] code, input logic eoc);
        int i;
        for (i = 0; i < 1000; i++)
        begin
            @(posedge pclk);
            #1;
            if ((ept_send | eoc_send) === 1'b1)
                break;
        end
        tmo(i, 1000);
        chk(32'({eoc_send, ept_send, out_dis}), 32'({eoc, !eoc, 1'b1}));
        if (!eoc)
            chk(32'(ept_code), 32'(code));
        apb(1'b0, ptt_pkg::ADDR_STATUS, 32'h0);
        if (!eoc)
            chk(32'(rd[10:8]), 32'(code[2:0]));
    endtask

    // Causes must be gone before clear, or the block rearms straight into pending
    task automatic rearm();
        @(posedge pclk);
        cz <= 6'h00;
        term_pin <= 1'b0;
        startup <= 1'b0;
        conv <= 1'b1;
        w4();
        apb(1'b1, ptt_pkg::ADDR_CTRL, 32'h3);
        apb(1'b0, ptt_pkg::ADDR_STATUS, 32'h0);
        chk(rd & 32'h3, 32'h0);
    endtask

    // Second pulse interval; the first wait discards a partial period
    task automatic gap(input int exp);
        int i;
        for (int k = 0; k < 2; k++)
        begin
            for (i = 1; i < 200; i++)
            begin
                @(posedge pclk);
                #1;
                if (err_req === 1'b1)
                    break;
            end
            tmo(i, 200);
        end
        chk(32'(i), 32'(exp));
    endtask

    initial
    begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ptt_pkg::ADDR_CTRL, 32'h0);
        chk(rd, 32'(ptt_pkg::CTRL_EN_RST));
        apb(1'b0, 8'h0C, 32'h0);
        chk({rd[30:0], er}, 32'h1);
        for (int j = 0; j < 8; j++)
        begin
            cz <= cz_t[j];
            term(cd_t[j], 1'b0);
            rearm();
        end
        chk(32'(low_power), 32'h1);
        pma <= 1'b1;
        cz <= 6'h10;
        term(8'h03, 1'b1);
        rearm();
        term_pin <= 1'b1;
        term(8'h00, 1'b1);
        rearm();
        cz <= 6'h02;
        term(8'h01, 1'b1);
        rearm();
        pma <= 1'b0;
        term_pin <= 1'b1;
        repeat (40) @(posedge pclk);
        apb(1'b0, ptt_pkg::ADDR_STATUS, 32'h0);
        chk(rd & 32'h3, 32'h0);
        rearm();
        apb(1'b1, ptt_pkg::ADDR_CTRL, 32'h0);
        cz <= 6'h01;
        repeat (40) @(posedge pclk);
        apb(1'b0, ptt_pkg::ADDR_STATUS, 32'h0);
        chk(rd & 32'h3, 32'h0);
        rearm();
        startup <= 1'b1;
        conv <= 1'b0;
        term(8'h04, 1'b0);
        chk(32'(power_off), 32'h1);
        apb(1'b0, ptt_pkg::ADDR_COUNT, 32'h0);
        chk(rd, 32'(ptt_pkg::STARTUP_PKTS));
        rearm();
        comm <= 1'b1;
        for (int j = 0; j < 4; j++)
        begin
            @(posedge pclk);
            load <= ld_t[j];
            w4();
            chk(32'({lim_on, lim_on ? lim_ma : 12'h000}), 32'(lm_t[j]));
        end
        @(posedge pclk);
        lim_dis <= 1'b1;
        ping_hi <= 1'b1;
        w4();
        chk(32'({lim_on, pd_oe, pd_o}), 32'h2);
        @(posedge pclk);
        lim_dis <= 1'b0;
        pma <= 1'b1;
        w4();
        chk(32'({lim_on, pd_oe}), 32'h0);
        @(posedge pclk);
        pma <= 1'b0;
        surge <= 1'b1;
        w4();
        gap(20);
        @(posedge pclk);
        surge <= 1'b0;
        w4();
        gap(50);
        @(posedge pclk);
        ce <= 1'b0;
        ovp <= 1'b1;
        w4();
        chk(32'(reg_off), 32'h0);
        @(posedge pclk);
        ce <= 1'b1;
        w4();
        chk(32'(reg_off), 32'h1);
        close_out();
    end
endmodule
`default_nettype wire
